// file: dv/acfg_host_model.sv
// Host model: issues register reads, writes and start/sleep commands.
// Assumes the bank samples every strobe on the rising edge of clk_in.
`timescale 1ns/1ns
`default_nettype none
module acfg_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       rvalid_in,
   output logic            wr_out,
   output logic            rd_out,
   output logic [1:0]      addr_out,
   output logic [7:0]      wdata_out,
   output logic            start_out,
   output logic            sleep_out
);
   initial begin
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = 2'h0;
      wdata_out = 8'h00;
      start_out = 1'b0;
      sleep_out = 1'b0;
   end

   task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk_in);
      wr_out    = 1'b1;
      addr_out  = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_out    = 1'b0;
      // Released data must not look valid
      wdata_out = ~d;
   endtask

   task automatic read_reg(input logic [1:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d  = 8'h00;
      @(negedge clk_in);
      rd_out   = 1'b1;
      addr_out = a;
      @(negedge clk_in);
      rd_out = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rvalid_in === 1'b1) begin
            ok = 1'b1;
            d  = rdata_in;
         end else begin
            @(negedge clk_in);
         end
      end
   endtask

   task automatic command(input logic s, input logic p);
      @(negedge clk_in);
      start_out = s;
      sleep_out = p;
      @(negedge clk_in);
      start_out = 1'b0;
      sleep_out = 1'b0;
   endtask

   // Write, then read back on the very next edge
   task automatic write_read(input logic [1:0] a, input logic [7:0] d, output logic [7:0] q, output bit ok);
      ok = 1'b0;
      q  = 8'h00;
      @(negedge clk_in);
      wr_out    = 1'b1;
      addr_out  = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_out    = 1'b0;
      rd_out    = 1'b1;
      wdata_out = ~d;
      @(negedge clk_in);
      rd_out = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rvalid_in === 1'b1) begin
            ok = 1'b1;
            q  = rdata_in;
         end else begin
            @(negedge clk_in);
         end
      end
   endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the configuration bank, registers one to three.
// Assumes the host model drives every strobe; reference model uses ints.
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench;
   import acfg_pkg::*;
   logic clk_in, rst_in, wr, rd, start, sleep, rdy, rvalid, ign, burn, sw, dpin, spin, style, therm;
   logic [1:0]  addr, mode, refs, lrej;
   logic [7:0]  wdata, rdata;
   logic [2:0]  rate, ilvl, rt1, rt2;
   logic [13:0] rx4;
   logic [9:0]  mkhz;
   logic [10:0] iua;
   int          m [4];
   int          bad_count, check_count;
   int unsigned seed;

   acfg_bank u_acfg_bank (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .start_cmd_in(start), .sleep_cmd_in(sleep),
      .data_ready_in(rdy), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .output_rate_select_out(rate),
      .op_mode_out(mode), .conversion_style_bit_out(style), .thermal_sensor_enable_out(therm),
      .input_setup_ignored_out(ign), .burnout_source_enable_out(burn), .ref_select_out(refs),
      .line_reject_out(lrej), .excitation_current_level_out(ilvl), .first_source_route_out(rt1),
      .second_source_route_out(rt2), .rate_x4_out(rx4), .mod_khz_out(mkhz), .idac_ua_out(iua),
      .low_side_switch_closed_out(sw), .dedicated_ready_pin_out(dpin), .shared_data_out_pin_ready_out(spin));
   acfg_host_model u_acfg_host_model (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
      .rd_out(rd), .addr_out(addr), .wdata_out(wdata), .start_out(start), .sleep_out(sleep));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function automatic int rate4(int md, int r);
      int nt[8] = '{80, 180, 360, 700, 1320, 2400, 4000, 0};
      int dt[8] = '{20, 45, 90, 176, 330, 600, 1000, 0};
      if (md == 0) return nt[r];
      if (md == 1) return dt[r];
      if (md == 2) return 2 * nt[r];
      return 0;
   endfunction

   function automatic int idac(int c);
      int t[8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
      return t[c];
   endfunction

   // Keeps random traffic within what a host may legally send
   function automatic logic [7:0] legal(int a, logic [7:0] d);
      if (a == 1 && d[7:5] == 3'h7) d[7:5] = 3'h6;
      if (a == 1 && d[4:3] == 2'h3) d[4:3] = 2'h0;
      if (a == 2 && d[2:0] == 3'h1) d[2:0] = 3'h2;
      if (a == 3 && d[7:5] == 3'h7) d[7:5] = 3'h6;
      if (a == 3 && d[4:2] == 3'h7) d[4:2] = 3'h6;
      if (a == 3) d[0] = 1'b0;
      if (a == 2 && (m[1][7:5] != 0 || m[1][4])) d[5:4] = 2'h0;
      if (a == 1 && m[2][5:4] != 0) d[7:4] = 4'h0;
      return d;
   endfunction

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_all();
      int c1, c2, c3;
      c1 = m[1];
      c2 = m[2];
      c3 = m[3];
      `TB_CHK(rate, c1[7:5])
      `TB_CHK(mode, c1[4:3])
      `TB_CHK(style, c1[2])
      `TB_CHK(therm, c1[1])
      `TB_CHK(ign, c1[1])
      `TB_CHK(burn, c1[0])
      `TB_CHK(refs, c1[1] ? 0 : c2[7:6])
      `TB_CHK(lrej, c2[5:4])
      `TB_CHK(ilvl, c2[2:0])
      `TB_CHK(rt1, c3[7:5])
      `TB_CHK(rt2, c3[4:2])
      `TB_CHK(rx4, rate4(c1[4:3], c1[7:5]))
      `TB_CHK(mkhz, (c1[4:3] == 2) ? 512 : ((c1[4:3] == 3) ? 0 : 256))
      `TB_CHK(iua, idac(c2[2:0]))
   endtask

   // Decoded outputs settle one edge after the write edge
   task automatic wr_reg(int a, logic [7:0] d);
      u_acfg_host_model.write_reg(a[1:0], d);
      if (a != 0) m[a] = d;
      repeat (2) @(negedge clk_in);
      check_all();
   endtask

   task automatic rd_chk(int a);
      logic [7:0] d;
      bit         ok;
      u_acfg_host_model.read_reg(a[1:0], d, ok);
      if (!ok) begin
         bad_count++;
         print_verdict();
      end else begin
         `TB_CHK(d, (a == 0) ? 0 : m[a])
      end
   endtask

   // Read issued on the edge right after the write must see the new value
   task automatic wrrd_chk(logic [7:0] d);
      logic [7:0] q;
      bit         ok;
      u_acfg_host_model.write_read(2'h2, d, q, ok);
      m[2] = d;
      if (!ok) begin
         bad_count++;
         print_verdict();
      end else begin
         `TB_CHK(q, m[2])
      end
   endtask

   task automatic cmd_chk(logic s, logic p, logic e);
      u_acfg_host_model.command(s, p);
      `TB_CHK(sw, e)
   endtask

   initial begin
      logic [7:0] d;
      int         a;
      rst_in = 1'b1;
      rdy    = 1'b0;
      m      = '{0, 0, 0, 0};
      seed   = $urandom(32'hCDF3);
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      // Decoded outputs hold reset zeros until the first edge after release
      repeat (2) @(negedge clk_in);
      check_all();
      for (int i = 0; i < 4; i++) rd_chk(i);
      // Every legal mode and rate, filter still off
      for (int md = 0; md < 3; md++)
         for (int r = 0; r < 7; r++) wr_reg(1, {r[2:0], md[1:0], 3'h0});
      // Rejection codes only at the slowest normal rate
      wr_reg(1, 8'h00);
      for (int v = 0; v < 8; v++) begin
         wr_reg(2, legal(2, {v[1:0], v[1:0], 1'b0, v[2:0]}));
         wr_reg(1, 8'h02);
         wr_reg(1, 8'h00);
      end
      wr_reg(0, 8'hFF);
      rd_chk(0);
      for (int i = 0; i < 40; i++) begin
         a = 1 + ($urandom % 3);
         d = legal(a, 8'($urandom));
         wr_reg(a, d);
         rd_chk(a);
      end
      wrrd_chk(legal(2, 8'($urandom)));
      wr_reg(2, 8'h00);
      cmd_chk(1'b1, 1'b0, 1'b0);
      wr_reg(2, 8'h08);
      cmd_chk(1'b1, 1'b0, 1'b1);
      cmd_chk(1'b0, 1'b1, 1'b0);
      cmd_chk(1'b1, 1'b0, 1'b1);
      cmd_chk(1'b1, 1'b1, 1'b0);
      rd_chk(2);
      cmd_chk(1'b1, 1'b0, 1'b1);
      wr_reg(2, 8'h00);
      `TB_CHK(sw, 1'b0)
      for (int rm = 0; rm < 2; rm++) begin
         wr_reg(3, {6'h00, rm[0], 1'b0});
         rdy = 1'b1;
         @(negedge clk_in);
         `TB_CHK(dpin, 1'b1)
         `TB_CHK(spin, rm[0])
         rdy = 1'b0;
         @(negedge clk_in);
         `TB_CHK(dpin | spin, 1'b0)
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// file: hw/acfg_bank.sv
// Configuration registers one to three of a delta-sigma converter.
// Assumes the command decoder delivers same-clock read, write and command pulses.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Rate field meaning depends on mode
// - Mode selects normal, duty-cycle or turbo
// - Bit two picks single-shot or continuous
// - Thermal sensor forces internal reference, ignores input setup
// - Bit zero switches burn-out sources
// - Rate codes map to fixed sample rates
// - Rates scale with external clock frequency; the bank uses a fixed rate table instead
// - Reference select chooses four references
// - Line-rejection field chooses filter coefficients
// - Low-side switch closes on start, opens on sleep
// - Excitation field sets both source magnitudes
// - All three registers reset to zero
// - Eight-bit registers, kept through power-down
// - Ready mode adds readiness on shared pin
module acfg_bank
   import acfg_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [1:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        start_cmd_in,
   input  wire logic        sleep_cmd_in,
   input  wire logic        data_ready_in,
   output logic [7:0]       reg_rdata_out,
   output logic             reg_rvalid_out,
   output logic [2:0]       output_rate_select_out,
   output logic [1:0]       op_mode_out,
   output logic             conversion_style_bit_out,
   output logic             thermal_sensor_enable_out,
   output logic             input_setup_ignored_out,
   output logic             burnout_source_enable_out,
   output logic [1:0]       ref_select_out,
   output logic [1:0]       line_reject_out,
   output logic [2:0]       excitation_current_level_out,
   output logic [2:0]       first_source_route_out,
   output logic [2:0]       second_source_route_out,
   output logic [13:0]      rate_x4_out,
   output logic [9:0]       mod_khz_out,
   output logic [10:0]      idac_ua_out,
   output logic             low_side_switch_closed_out,
   output logic             dedicated_ready_pin_out,
   output logic             shared_data_out_pin_ready_out
);
   logic [7:0]  conv_q;
   logic [7:0]  conv_d;
   logic [7:0]  ref_q;
   logic [7:0]  ref_d;
   logic [7:0]  route_q;
   logic [7:0]  route_d;
   logic [7:0]  rdata_q;
   logic        rvalid_q;
   logic [13:0] rate_q;
   logic [9:0]  khz_q;
   logic [10:0] idac_q;
   logic [1:0]  ref_eff_q;
   acfg_sw_e    sw_q;
   acfg_sw_e    sw_d;
   logic        rdy_ded_q;
   logic        rdy_shr_q;

   acfg_cfg_if cfg_bus ();

   acfg_decode u_dec (
      .cfg (cfg_bus.dec)
   );

   assign cfg_bus.conv_cfg = conv_q;
   assign cfg_bus.ref_cfg  = ref_q;

   wire logic wr_conv  = reg_wr_in && (reg_addr_in == ACFG_ADDR_CONV);
   wire logic wr_ref   = reg_wr_in && (reg_addr_in == ACFG_ADDR_REFFLT);
   wire logic wr_route = reg_wr_in && (reg_addr_in == ACFG_ADDR_ROUTE);
   assign conv_d  = wr_conv  ? reg_wdata_in : conv_q;
   assign ref_d   = wr_ref   ? reg_wdata_in : ref_q;
   assign route_d = wr_route ? reg_wdata_in : route_q;

   // Address zero belongs to another bank, so it reads as zero here
   wire logic [7:0] rd_sel = (reg_addr_in == ACFG_ADDR_CONV)   ? conv_q :
                             (reg_addr_in == ACFG_ADDR_REFFLT) ? ref_q  :
                             (reg_addr_in == ACFG_ADDR_ROUTE)  ? route_q : 8'h00;

   wire logic psw_en   = ref_q[ACFG_PSW_BIT];
   wire logic therm_en = conv_q[ACFG_THERM_BIT];

   always_comb begin
      sw_d = sw_q;
      case (sw_q)
         ACFG_SW_OPEN: begin
            if (psw_en && start_cmd_in && !sleep_cmd_in) begin
               sw_d = ACFG_SW_CLOSED;
            end
         end
         ACFG_SW_CLOSED: begin
            if (sleep_cmd_in || !psw_en) begin
               sw_d = ACFG_SW_OPEN;
            end
         end
         default: sw_d = ACFG_SW_OPEN;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         conv_q  <= ACFG_RESET_VAL;
         ref_q   <= ACFG_RESET_VAL;
         route_q <= ACFG_RESET_VAL;
      end else begin
         conv_q  <= conv_d;
         ref_q   <= ref_d;
         route_q <= route_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= reg_rd_in ? rd_sel : rdata_q;
         rvalid_q <= reg_rd_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rate_q    <= 14'h0000;
         khz_q     <= 10'h000;
         idac_q    <= 11'h000;
         ref_eff_q <= ACFG_REF_INTERNAL;
         sw_q      <= ACFG_SW_OPEN;
      end else begin
         rate_q    <= cfg_bus.rate_x4;
         khz_q     <= cfg_bus.mod_khz;
         idac_q    <= cfg_bus.idac_ua;
         ref_eff_q <= therm_en ? ACFG_REF_INTERNAL : ref_q[ACFG_REF_MSB:ACFG_REF_LSB];
         sw_q      <= sw_d;
      end
   end

   // Ready on both pins when mode set
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdy_ded_q <= 1'b0;
         rdy_shr_q <= 1'b0;
      end else begin
         rdy_ded_q <= data_ready_in;
         rdy_shr_q <= data_ready_in && route_q[ACFG_RDYM_BIT];
      end
   end

   assign reg_rdata_out                = rdata_q;
   assign reg_rvalid_out               = rvalid_q;
   assign output_rate_select_out       = conv_q[ACFG_RATE_MSB:ACFG_RATE_LSB];
   assign op_mode_out                  = conv_q[ACFG_MODE_MSB:ACFG_MODE_LSB];
   assign conversion_style_bit_out     = conv_q[ACFG_STYLE_BIT];
   assign thermal_sensor_enable_out    = therm_en;
   assign input_setup_ignored_out      = therm_en;
   assign burnout_source_enable_out    = conv_q[ACFG_BURN_BIT];
   assign ref_select_out               = ref_eff_q;
   assign line_reject_out              = ref_q[ACFG_FLT_MSB:ACFG_FLT_LSB];
   assign excitation_current_level_out = ref_q[ACFG_IDAC_MSB:ACFG_IDAC_LSB];
   assign first_source_route_out       = route_q[ACFG_R1_MSB:ACFG_R1_LSB];
   assign second_source_route_out      = route_q[ACFG_R2_MSB:ACFG_R2_LSB];
   assign rate_x4_out                  = rate_q;
   assign mod_khz_out                  = khz_q;
   assign idac_ua_out                  = idac_q;
   assign low_side_switch_closed_out   = (sw_q == ACFG_SW_CLOSED);
   assign dedicated_ready_pin_out      = rdy_ded_q;
   assign shared_data_out_pin_ready_out = rdy_shr_q;

   property p_reset_zero;
      @(posedge clk_in) $past(rst_in) |-> (conv_q == 8'h00 && ref_q == 8'h00 && route_q == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("bank not zero after reset");

   property p_write_read;
      @(posedge clk_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == ACFG_ADDR_REFFLT) ##1 (reg_rd_in && !reg_wr_in && reg_addr_in == ACFG_ADDR_REFFLT)
      |=> (reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 2));
   endproperty
   a_write_read: assert property (p_write_read) else $error("read back differs from write");

   property p_sleep_keeps;
      @(posedge clk_in) disable iff (rst_in)
      (sleep_cmd_in && !reg_wr_in) |=> ($stable(conv_q) && $stable(ref_q) && $stable(route_q));
   endproperty
   a_sleep_keeps: assert property (p_sleep_keeps) else $error("sleep altered a register");

   property p_rate_normal;
      @(posedge clk_in) disable iff (rst_in)
      (conv_q[7:3] == 5'h00) ##1 (conv_q[7:3] == 5'h00) |-> (rate_x4_out == 14'h0050);
   endproperty
   a_rate_normal: assert property (p_rate_normal) else $error("normal code zero not 20 per second");

   property p_rate_turbo;
      @(posedge clk_in) disable iff (rst_in)
      (conv_q[7:3] == 5'h1A) ##1 (conv_q[7:3] == 5'h1A) |-> (rate_x4_out == 14'h1F40 && mod_khz_out == 10'h200);
   endproperty
   a_rate_turbo: assert property (p_rate_turbo) else $error("turbo top rate wrong");

   property p_therm_ref;
      @(posedge clk_in) disable iff (rst_in)
      therm_en |=> (ref_select_out == ACFG_REF_INTERNAL);
   endproperty
   a_therm_ref: assert property (p_therm_ref) else $error("thermal mode not on internal reference");

   property p_switch_close;
      @(posedge clk_in) disable iff (rst_in)
      (psw_en && start_cmd_in && !sleep_cmd_in) |=> low_side_switch_closed_out;
   endproperty
   a_switch_close: assert property (p_switch_close) else $error("switch failed to close on start");

   property p_switch_open;
      @(posedge clk_in) disable iff (rst_in)
      (sleep_cmd_in || !psw_en) |=> !low_side_switch_closed_out;
   endproperty
   a_switch_open: assert property (p_switch_open) else $error("switch closed while it should be open");

   property p_ready_mode;
      @(posedge clk_in) disable iff (rst_in)
      data_ready_in |=> (dedicated_ready_pin_out && shared_data_out_pin_ready_out == $past(route_q[ACFG_RDYM_BIT]));
   endproperty
   a_ready_mode: assert property (p_ready_mode) else $error("ready pins disagree with mode");

   property p_idac_top;
      @(posedge clk_in) disable iff (rst_in)
      (ref_q[2:0] == 3'h7) ##1 (ref_q[2:0] == 3'h7) |-> (idac_ua_out == 11'h5DC);
   endproperty
   a_idac_top: assert property (p_idac_top) else $error("top excitation code not 1500 uA");
endmodule
`default_nettype wire

// file: hw/acfg_cfg_if.sv
// Carries stored configuration to the decoder and decoded values back.
// Assumes both ends share the bank's clock.
`timescale 1ns/1ns
`default_nettype none
interface acfg_cfg_if;
   logic [7:0]  conv_cfg;
   logic [7:0]  ref_cfg;
   logic [13:0] rate_x4;
   logic [10:0] idac_ua;
   logic [9:0]  mod_khz;
   modport bank (output conv_cfg, output ref_cfg, input rate_x4, input idac_ua, input mod_khz);
   modport dec  (input conv_cfg, input ref_cfg, output rate_x4, output idac_ua, output mod_khz);
endinterface
`default_nettype wire

// file: hw/acfg_decode.sv
// Decodes rate, modulator clock and excitation current from stored fields.
// Purely combinational; the bank registers its outputs.
`timescale 1ns/1ns
`default_nettype none
module acfg_decode
   import acfg_pkg::*;
(
   acfg_cfg_if.dec cfg
);
   // Output rate times four, so fractional duty-cycle rates stay exact
   function automatic logic [13:0] rate_lookup(input logic [1:0] mode, input logic [2:0] code);
      logic [13:0] r;
      r = 14'h0000;
      case (mode)
         ACFG_MODE_NORMAL, ACFG_MODE_TURBO: begin
            case (code)
               3'h0: r = 14'h0050;
               3'h1: r = 14'h00B4;
               3'h2: r = 14'h0168;
               3'h3: r = 14'h02BC;
               3'h4: r = 14'h0528;
               3'h5: r = 14'h0960;
               3'h6: r = 14'h0FA0;
               default: r = 14'h0000;
            endcase
            if (mode == ACFG_MODE_TURBO) begin
               r = {r[12:0], 1'b0};
            end
         end
         ACFG_MODE_DUTY: begin
            case (code)
               3'h0: r = 14'h0014;
               3'h1: r = 14'h002D;
               3'h2: r = 14'h005A;
               3'h3: r = 14'h00B0;
               3'h4: r = 14'h014A;
               3'h5: r = 14'h0258;
               3'h6: r = 14'h03E8;
               default: r = 14'h0000;
            endcase
         end
         default: r = 14'h0000;
      endcase
      return r;
   endfunction

   wire logic [1:0] mode = cfg.conv_cfg[ACFG_MODE_MSB:ACFG_MODE_LSB];
   wire logic [2:0] code = cfg.conv_cfg[ACFG_RATE_MSB:ACFG_RATE_LSB];
   wire logic [2:0] idac = cfg.ref_cfg[ACFG_IDAC_MSB:ACFG_IDAC_LSB];

   // Rates hold at 4.096 MHz timebase
   assign cfg.rate_x4 = rate_lookup(mode, code);

   assign cfg.mod_khz = (mode == ACFG_MODE_TURBO) ? ACFG_MOD_KHZ_TURBO :
                        (mode == 2'h3) ? 10'h000 : ACFG_MOD_KHZ_NORMAL;

   assign cfg.idac_ua = (idac == 3'h2) ? 11'h032 :
                        (idac == 3'h3) ? 11'h064 :
                        (idac == 3'h4) ? 11'h0FA :
                        (idac == 3'h5) ? 11'h1F4 :
                        (idac == 3'h6) ? 11'h3E8 :
                        (idac == 3'h7) ? 11'h5DC : 11'h000;
endmodule
`default_nettype wire

// file: hw/acfg_pkg.sv
// Constants for the converter configuration bank, registers one to three.
// Assumes the bank is reached by register read and write commands.
package acfg_pkg;
   localparam logic [1:0] ACFG_ADDR_CONV   = 2'h1;
   localparam logic [1:0] ACFG_ADDR_REFFLT = 2'h2;
   localparam logic [1:0] ACFG_ADDR_ROUTE  = 2'h3;
   localparam logic [7:0] ACFG_RESET_VAL   = 8'h00;

   // Conversion control register fields
   localparam int ACFG_RATE_MSB  = 7;
   localparam int ACFG_RATE_LSB  = 5;
   localparam int ACFG_MODE_MSB  = 4;
   localparam int ACFG_MODE_LSB  = 3;
   localparam int ACFG_STYLE_BIT = 2;
   localparam int ACFG_THERM_BIT = 1;
   localparam int ACFG_BURN_BIT  = 0;
   // Reference, filter and current register fields
   localparam int ACFG_REF_MSB   = 7;
   localparam int ACFG_REF_LSB   = 6;
   localparam int ACFG_FLT_MSB   = 5;
   localparam int ACFG_FLT_LSB   = 4;
   localparam int ACFG_PSW_BIT   = 3;
   localparam int ACFG_IDAC_MSB  = 2;
   localparam int ACFG_IDAC_LSB  = 0;
   // Current routing register fields
   localparam int ACFG_R1_MSB    = 7;
   localparam int ACFG_R1_LSB    = 5;
   localparam int ACFG_R2_MSB    = 4;
   localparam int ACFG_R2_LSB    = 2;
   localparam int ACFG_RDYM_BIT  = 1;

   localparam logic [1:0] ACFG_MODE_NORMAL = 2'h0;
   localparam logic [1:0] ACFG_MODE_DUTY   = 2'h1;
   localparam logic [1:0] ACFG_MODE_TURBO  = 2'h2;
   localparam logic [1:0] ACFG_REF_INTERNAL = 2'h0;
   localparam logic [9:0] ACFG_MOD_KHZ_NORMAL = 10'h100;
   localparam logic [9:0] ACFG_MOD_KHZ_TURBO  = 10'h200;

   typedef enum logic {
      ACFG_SW_OPEN   = 1'b0,
      ACFG_SW_CLOSED = 1'b1
   } acfg_sw_e;
endpackage
